// ### pkg/opdata_pkg.sv
// constants, register map and entry layout for the operation data selector
package opdata_pkg;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_ENTRIES = 16;
    localparam int ENTRY_W = 4;
    localparam int NUM_TERMS = 4;
    localparam int SPEED_W = 12;
    localparam int RAMP_W = 15;
    localparam int TORQ_W = 8;
    localparam int ACC_W = 17;
    // ************************************************************
    // value ranges and reset values
    // ************************************************************
    localparam logic [SPEED_W-1:0] SPEED_MAX = 12'hfa0;
    localparam logic [SPEED_W-1:0] SPEED_AN_MIN = 12'h01e;
    localparam logic [SPEED_W-1:0] SPEED_INIT = 12'h000;
    localparam logic [SPEED_W-1:0] SPEED_RATED = 12'hbb8;
    localparam logic [RAMP_W-1:0] RAMP_MAX = 15'h7530;
    localparam logic [RAMP_W-1:0] RAMP_AN_MIN = 15'h0064;
    localparam logic [RAMP_W-1:0] RAMP_INIT = 15'h0064;
    localparam logic [TORQ_W-1:0] TORQ_MAX = 8'hfa;
    localparam logic [TORQ_W-1:0] TORQ_INIT = 8'hfa;
    localparam logic [TORQ_W-1:0] TORQ_PEAK = 8'hfa;
    // ************************************************************
    // source selector encodings
    // ************************************************************
    localparam logic [7:0] SRC_DIGITAL = 8'h00;
    localparam logic [7:0] SRC_AN_SPEED = 8'h01;
    localparam logic [7:0] SRC_AN_TORQUE = 8'h02;
    localparam logic [7:0] RAMP_SRC_AN = 8'h01;
    localparam logic [7:0] SRC_RESET = 8'h01;
    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_SPD_TRQ_SRC = 8'h00;
    localparam logic [7:0] OFS_RAMP_SRC = 8'h04;
    localparam logic [7:0] OFS_ENTRY_IDX = 8'h08;
    localparam logic [7:0] OFS_ENTRY_SPEED = 8'h0c;
    localparam logic [7:0] OFS_ENTRY_ACCEL = 8'h10;
    localparam logic [7:0] OFS_ENTRY_DECEL = 8'h14;
    localparam logic [7:0] OFS_ENTRY_TORQ = 8'h18;
    localparam logic [7:0] OFS_CAP_ASSIGN = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_SPEED_CMD = 8'h24;
    localparam logic [7:0] OFS_TORQ_LIMIT = 8'h28;
    localparam int ST_CAP_BIT = 4;
    localparam int ST_RAMP_BIT = 5;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int RAMP_UNIT_NS = 1000000;
    localparam int MS_CYCLES = RAMP_UNIT_NS / CLK_PERIOD_NS;
    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [SPEED_W-1:0] speed;
        logic [RAMP_W-1:0] accel;
        logic [RAMP_W-1:0] decel;
        logic [TORQ_W-1:0] torque;
    } entry_t;
    typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ramp_state_t;
endpackage : opdata_pkg

// ### src/speed_mode_operation_data_select.sv
// operation data store, source selection, torque cap and speed ramp
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
// Functional notes
// - sixteen entries 0..15, each speed, accel time, decel time, torque limit
// - speed/torque selector resets to 1; 0 digital, 1 analog speed, 2 analog torque
// - selector 1: entry 0 internal knob speed, entry 1 external speed
// - selector 2: entries 0 and 1 torque from external analog, speed digital
// - ramp selector resets to 1; 1 takes entries 0,1 ramps from knobs
// - speed digital 0..4000; analog 0 or 30..4000; initial zero
// - ramp in ms, digital 0..30000, analog 100..30000, initial 100
// - ramp time means 0 to 3000 r/min or 3000 r/min to stop
// - torque limit 0..250 percent, initial 250
// - cap enabled limits torque, otherwise full peak torque
// - cap function on no terminal counts as always active
// - cap function on several terminals needs all of them on
module speed_mode_operation_data_select #(
    parameter int MS_CYCLES = opdata_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // input terminals
    input wire logic [opdata_pkg::ENTRY_W-1:0] data_select_i,
    input wire logic [opdata_pkg::NUM_TERMS-1:0] torque_cap_enable_input_i,
    // digitised analog sources
    input wire logic [opdata_pkg::SPEED_W-1:0] int_speed_knob_i,
    input wire logic [opdata_pkg::SPEED_W-1:0] ext_speed_i,
    input wire logic [opdata_pkg::TORQ_W-1:0] ext_torque_i,
    input wire logic [opdata_pkg::RAMP_W-1:0] accel_time_knob_i,
    input wire logic [opdata_pkg::RAMP_W-1:0] decel_time_knob_i,
    // speed loop
    output logic [opdata_pkg::SPEED_W-1:0] speed_cmd_o,
    output logic [opdata_pkg::TORQ_W-1:0] torque_limit_o,
    output logic torque_cap_active_o,
    output logic [opdata_pkg::ENTRY_W-1:0] active_entry_o
);
    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic analog_pair(input logic [opdata_pkg::ENTRY_W-1:0] e);
        analog_pair = (e < 4'h2);
    endfunction : analog_pair
    function automatic logic [opdata_pkg::SPEED_W-1:0] an_speed(
        input logic [opdata_pkg::SPEED_W-1:0] v);
        if (v < opdata_pkg::SPEED_AN_MIN)
            an_speed = 12'h000;
        else if (v > opdata_pkg::SPEED_MAX)
            an_speed = opdata_pkg::SPEED_MAX;
        else
            an_speed = v;
    endfunction : an_speed
    function automatic logic [opdata_pkg::RAMP_W-1:0] an_ramp(
        input logic [opdata_pkg::RAMP_W-1:0] v);
        if (v < opdata_pkg::RAMP_AN_MIN)
            an_ramp = opdata_pkg::RAMP_AN_MIN;
        else if (v > opdata_pkg::RAMP_MAX)
            an_ramp = opdata_pkg::RAMP_MAX;
        else
            an_ramp = v;
    endfunction : an_ramp
    function automatic logic [opdata_pkg::TORQ_W-1:0] cl_torque(
        input logic [opdata_pkg::TORQ_W-1:0] v);
        cl_torque = (v > opdata_pkg::TORQ_MAX) ? opdata_pkg::TORQ_MAX : v;
    endfunction : cl_torque
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] sel);
        for (int i = 0; i < 4; i++)
            wmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    endfunction : wmerge
    // ************************************************************
    // bus slave
    // ************************************************************
    logic [7:0] spd_trq_src;
    logic [7:0] ramp_src;
    logic [opdata_pkg::ENTRY_W-1:0] entry_idx;
    logic [opdata_pkg::NUM_TERMS-1:0] cap_assign;
    opdata_pkg::entry_t table_q [opdata_pkg::NUM_ENTRIES];
    opdata_pkg::ramp_state_t ramp_state;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic bus_req;
    logic bus_wr;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i;
    assign wr_word = wmerge(rd_word, wb_dat_i, wb_sel_i);
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (wb_adr_i)
            opdata_pkg::OFS_SPD_TRQ_SRC: rd_word[7:0] = spd_trq_src;
            opdata_pkg::OFS_RAMP_SRC: rd_word[7:0] = ramp_src;
            opdata_pkg::OFS_ENTRY_IDX: rd_word[3:0] = entry_idx;
            opdata_pkg::OFS_ENTRY_SPEED: rd_word[11:0] = table_q[entry_idx].speed;
            opdata_pkg::OFS_ENTRY_ACCEL: rd_word[14:0] = table_q[entry_idx].accel;
            opdata_pkg::OFS_ENTRY_DECEL: rd_word[14:0] = table_q[entry_idx].decel;
            opdata_pkg::OFS_ENTRY_TORQ: rd_word[7:0] = table_q[entry_idx].torque;
            opdata_pkg::OFS_CAP_ASSIGN: rd_word[3:0] = cap_assign;
            opdata_pkg::OFS_STATUS:
            begin
                rd_word[3:0] = active_entry_o;
                rd_word[opdata_pkg::ST_CAP_BIT] = torque_cap_active_o;
                rd_word[opdata_pkg::ST_RAMP_BIT] = (ramp_state != opdata_pkg::RAMP_IDLE);
            end
            opdata_pkg::OFS_SPEED_CMD: rd_word[11:0] = speed_cmd_o;
            opdata_pkg::OFS_TORQ_LIMIT: rd_word[7:0] = torque_limit_o;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
                wb_dat_o <= rd_word;
        end
    end
    // source selectors, entry index and cap assignment; out-of-range selector codes are ignored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            spd_trq_src <= opdata_pkg::SRC_RESET;
            ramp_src <= opdata_pkg::SRC_RESET;
            entry_idx <= 4'h0;
            cap_assign <= 4'h0;
        end
        else if (bus_wr)
        begin
            case (wb_adr_i)
                opdata_pkg::OFS_SPD_TRQ_SRC:
                    if (wr_word[7:0] <= opdata_pkg::SRC_AN_TORQUE)
                        spd_trq_src <= wr_word[7:0];
                opdata_pkg::OFS_RAMP_SRC:
                    if (wr_word[7:0] <= opdata_pkg::RAMP_SRC_AN)
                        ramp_src <= wr_word[7:0];
                opdata_pkg::OFS_ENTRY_IDX: entry_idx <= wr_word[3:0];
                opdata_pkg::OFS_CAP_ASSIGN: cap_assign <= wr_word[3:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // operation data table
    // ************************************************************
    for (genvar g = 0; g < opdata_pkg::NUM_ENTRIES; g++)
    begin : g_entry
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                table_q[g].speed <= opdata_pkg::SPEED_INIT;
                table_q[g].accel <= opdata_pkg::RAMP_INIT;
                table_q[g].decel <= opdata_pkg::RAMP_INIT;
                table_q[g].torque <= opdata_pkg::TORQ_INIT;
            end
            else if (bus_wr && entry_idx == 4'(g))
            begin
                case (wb_adr_i)
                    opdata_pkg::OFS_ENTRY_SPEED:
                        table_q[g].speed <= (wr_word > 32'(opdata_pkg::SPEED_MAX)) ?
                            opdata_pkg::SPEED_MAX : wr_word[11:0];
                    opdata_pkg::OFS_ENTRY_ACCEL:
                        table_q[g].accel <= (wr_word > 32'(opdata_pkg::RAMP_MAX)) ?
                            opdata_pkg::RAMP_MAX : wr_word[14:0];
                    opdata_pkg::OFS_ENTRY_DECEL:
                        table_q[g].decel <= (wr_word > 32'(opdata_pkg::RAMP_MAX)) ?
                            opdata_pkg::RAMP_MAX : wr_word[14:0];
                    opdata_pkg::OFS_ENTRY_TORQ:
                        table_q[g].torque <= (wr_word > 32'(opdata_pkg::TORQ_MAX)) ?
                            opdata_pkg::TORQ_MAX : wr_word[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // source selection
    // ************************************************************
    opdata_pkg::entry_t cur;
    opdata_pkg::entry_t sel_q;
    logic cap_on;
    always_comb
    begin
        cur = table_q[active_entry_o];
        if (spd_trq_src == opdata_pkg::SRC_AN_SPEED && active_entry_o == 4'h0)
            cur.speed = an_speed(int_speed_knob_i);
        else if (spd_trq_src == opdata_pkg::SRC_AN_SPEED && active_entry_o == 4'h1)
            cur.speed = an_speed(ext_speed_i);
        if (spd_trq_src == opdata_pkg::SRC_AN_TORQUE && analog_pair(active_entry_o))
            cur.torque = cl_torque(ext_torque_i);
        if (ramp_src == opdata_pkg::RAMP_SRC_AN && analog_pair(active_entry_o))
        begin
            cur.accel = an_ramp(accel_time_knob_i);
            cur.decel = an_ramp(decel_time_knob_i);
        end
    end
    // unassigned terminals pass; no assignment at all leaves it active
    assign cap_on = ((torque_cap_enable_input_i & cap_assign) == cap_assign);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            active_entry_o <= 4'h0;
            sel_q <= '0;
            torque_cap_active_o <= 1'b0;
            torque_limit_o <= opdata_pkg::TORQ_PEAK;
        end
        else
        begin
            active_entry_o <= data_select_i;
            sel_q <= cur;
            torque_cap_active_o <= cap_on;
            torque_limit_o <= cap_on ? cur.torque : opdata_pkg::TORQ_PEAK;
        end
    end

    // ************************************************************
    // speed ramp
    // ************************************************************
    logic [$clog2(MS_CYCLES)-1:0] ms_cnt;
    logic ms_tick;
    logic [opdata_pkg::ACC_W-1:0] acc;
    logic [opdata_pkg::ACC_W-1:0] next_acc;
    logic [opdata_pkg::RAMP_W-1:0] ramp_time;
    logic going_up;
    assign ms_tick = (ms_cnt == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
    assign going_up = (sel_q.speed > speed_cmd_o);
    assign ramp_time = going_up ? sel_q.accel : sel_q.decel;
    // each ms adds 3000 r/min worth; each ramp_time of credit is one r/min step
    assign next_acc = acc + (ms_tick ? 17'(opdata_pkg::SPEED_RATED) : 17'h0_0000);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || ms_tick)
            ms_cnt <= '0;
        else
            ms_cnt <= ms_cnt + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            speed_cmd_o <= opdata_pkg::SPEED_INIT;
            acc <= '0;
            ramp_state <= opdata_pkg::RAMP_IDLE;
        end
        else if (sel_q.speed == speed_cmd_o)
        begin
            acc <= '0;
            ramp_state <= opdata_pkg::RAMP_IDLE;
        end
        else if (ramp_time == 15'h0000)
        begin
            speed_cmd_o <= sel_q.speed;
            acc <= '0;
            ramp_state <= opdata_pkg::RAMP_IDLE;
        end
        else
        begin
            ramp_state <= going_up ? opdata_pkg::RAMP_UP : opdata_pkg::RAMP_DOWN;
            if (next_acc >= 17'(ramp_time))
            begin
                acc <= next_acc - 17'(ramp_time);
                speed_cmd_o <= going_up ? speed_cmd_o + 1'b1 : speed_cmd_o - 1'b1;
            end
            else
                acc <= next_acc;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_src_reset_val: assert property ($past(rst_i) |-> spd_trq_src == 8'h01 && ramp_src == 8'h01)
        else $error("source selectors not 1 after reset");
    a_int_knob_speed: assert property (spd_trq_src == 8'h01 && active_entry_o == 4'h0
        |=> sel_q.speed == an_speed($past(int_speed_knob_i)))
        else $error("entry 0 speed not from internal knob");
    a_ext_torque_sel: assert property (spd_trq_src == 8'h02 && active_entry_o < 4'h2
        && cap_on |=> torque_limit_o == cl_torque($past(ext_torque_i)))
        else $error("entry 0/1 torque not from external source");
    a_analog_ramp_rng: assert property (ramp_src == 8'h01 && active_entry_o < 4'h2
        |-> cur.accel >= 15'd100 && cur.accel <= 15'd30000
        && cur.decel >= 15'd100 && cur.decel <= 15'd30000)
        else $error("analog ramp time out of range");
    a_speed_cmd_max: assert property (speed_cmd_o <= 12'd4000)
        else $error("speed command above 4000");
    a_cap_peak_off: assert property (!cap_on |=> torque_limit_o == 8'd250 && !torque_cap_active_o)
        else $error("peak torque not allowed while cap off");
    a_cap_unassigned: assert property (cap_assign == 4'h0 |=> torque_cap_active_o)
        else $error("unassigned cap not active");
    a_cap_all_terms: assert property (cap_assign == 4'h3
        && torque_cap_enable_input_i[1:0] == 2'b01 |=> !torque_cap_active_o)
        else $error("cap active with one assigned terminal off");
    a_entry_binary: assert property (##1 active_entry_o == $past(data_select_i))
        else $error("active entry not data select code");
    a_ramp_one_step: assert property (ramp_time != 15'h0000 |=>
        (speed_cmd_o - $past(speed_cmd_o) == 12'h001) || (speed_cmd_o == $past(speed_cmd_o))
        || ($past(speed_cmd_o) - speed_cmd_o == 12'h001))
        else $error("ramp step larger than one r/min");
    a_ramp_zero_step: assert property (ramp_time == 15'h0000 |=> speed_cmd_o == $past(sel_q.speed))
        else $error("zero ramp time did not step");
    a_ramp_1ms_rate: assert property (ms_tick && going_up && ramp_time != 15'h0000
        && ramp_time <= 15'd3000 |=> speed_cmd_o == $past(speed_cmd_o) + 12'd1)
        else $error("ramp did not advance on ms credit");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    c_ext_speed: cover property (spd_trq_src == 8'h01 && active_entry_o == 4'h1);
    c_cap_off: cover property (!torque_cap_active_o ##1 torque_cap_active_o);
    c_ramp_done: cover property (ramp_state == opdata_pkg::RAMP_UP ##1
        ramp_state == opdata_pkg::RAMP_IDLE);
endmodule : speed_mode_operation_data_select

// ### tb/tb.sv
// self-checking testbench for the operation data selector
`timescale 1ns/1ps
module tb;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, use_ext = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, entry = 4'h0, caps = 4'h0, dsel, cap_t, act;
    logic [31:0] dat = 32'h0000_0000, rdat, q;
    logic [11:0] int_knob = 12'h000, ext_spd = 12'h000, spd;
    logic [7:0] ext_trq = 8'h00, trq;
    logic [14:0] acc_knob = 15'h0064, dec_knob = 15'h0064;
    logic cap_on;
    int err_total = 0, n_tests = 0;
    int exp_spd [3][3] = '{'{1000, 2000, 500}, '{1500, 2500, 500}, '{1000, 2000, 500}};
    int exp_trq [3][3] = '{'{50, 60, 70}, '{50, 60, 70}, '{90, 90, 70}};
    initial forever #50 clk_i = ~clk_i;
    terminal_host host_u (.entry_req_i(entry), .use_external_i(use_ext), .cap_levels_i(caps),
        .data_select_o(dsel), .torque_cap_enable_input_o(cap_t));
    speed_mode_operation_data_select #(.MS_CYCLES(40)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .data_select_i(dsel),
        .torque_cap_enable_input_i(cap_t), .int_speed_knob_i(int_knob), .ext_speed_i(ext_spd),
        .ext_torque_i(ext_trq), .accel_time_knob_i(acc_knob), .decel_time_knob_i(dec_knob),
        .speed_cmd_o(spd), .torque_limit_o(trq), .torque_cap_active_o(cap_on),
        .active_entry_o(act));
    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp
    task automatic cmp_rng(input string what, input int lo, input int hi, input logic [31:0] got);
        n_tests++;
        if (!(got >= lo && got <= hi) || $isunknown(got))
        begin
            err_total++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : cmp_rng
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            cmp("ack", 1, 0);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask : xfer
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(0, a, 32'h0000_0000);
        cmp(what, exp, q);
    endtask : rd_chk
    task automatic set_entry(input logic [3:0] i, input int s, input int t);
        xfer(1, 8'h08, {28'h000_0000, i});
        xfer(1, 8'h0c, 32'(s));
        xfer(1, 8'h10, 32'h0000_0000);
        xfer(1, 8'h14, 32'h0000_0000);
        xfer(1, 8'h18, 32'(t));
    endtask : set_entry
    task automatic pick(input logic [3:0] e, input int cycles);
        entry <= e;
        use_ext <= (e == 4'h1);
        repeat (cycles) @(posedge clk_i);
    endtask : pick
    // ************************************************************
    // test sequence
    // ************************************************************
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rd_chk("spd_trq_src", 8'h00, 32'h0000_0001);
        rd_chk("ramp_src", 8'h04, 32'h0000_0001);
        rd_chk("init_speed", 8'h0c, 32'h0000_0000);
        rd_chk("init_accel", 8'h10, 32'h0000_0064);
        rd_chk("init_decel", 8'h14, 32'h0000_0064);
        rd_chk("init_torque", 8'h18, 32'h0000_00fa);
        cmp("cap_unassigned", 1, cap_on);
        xfer(1, 8'h08, 32'h0000_000f);
        xfer(1, 8'h0c, 32'h0000_1388);
        xfer(1, 8'h10, 32'h0000_9c40);
        xfer(1, 8'h18, 32'h0000_012c);
        rd_chk("last_entry_idx", 8'h08, 32'h0000_000f);
        rd_chk("speed_clamp", 8'h0c, 32'h0000_0fa0);
        rd_chk("accel_clamp", 8'h10, 32'h0000_7530);
        rd_chk("torque_clamp", 8'h18, 32'h0000_00fa);
        set_entry(4'h0, 1000, 50);
        set_entry(4'h1, 2000, 60);
        set_entry(4'h2, 500, 70);
        xfer(1, 8'h04, 32'h0000_0000);
        int_knob <= 12'h5dc;
        ext_spd <= 12'h9c4;
        ext_trq <= 8'h5a;
        for (int s = 0; s < 3; s++)
        begin
            xfer(1, 8'h00, 32'(s));
            for (int e = 0; e < 3; e++)
            begin
                pick(4'(e), 10);
                cmp("active_entry", 32'(e), {28'h000_0000, act});
                cmp("speed_cmd", 32'(exp_spd[s][e]), {20'h0_0000, spd});
                cmp("torque_limit", 32'(exp_trq[s][e]), {24'h00_0000, trq});
            end
            if (s == 1)
            begin
                int_knob <= 12'h014;
                pick(4'h0, 10);
                cmp("analog_low_speed", 0, {20'h0_0000, spd});
            end
        end
        xfer(1, 8'h00, 32'h0000_0003);
        rd_chk("bad_selector", 8'h00, 32'h0000_0002);
        xfer(1, 8'h00, 32'h0000_0000);
        xfer(1, 8'h04, 32'h0000_0001);
        pick(4'h3, 800);
        cmp("ramp_down", 0, {20'h0_0000, spd});
        acc_knob <= 15'h0032;
        pick(4'h0, 400);
        cmp_rng("ramp_mid", 250, 330, {20'h0_0000, spd});
        repeat (1200) @(posedge clk_i);
        cmp("ramp_end", 1000, {20'h0_0000, spd});
        xfer(1, 8'h24, 32'h0000_0000);
        rd_chk("speed_cmd_ro", 8'h24, 32'h0000_03e8);
        rd_chk("unmapped", 8'h3c, 32'h0000_0000);
        xfer(1, 8'h1c, 32'h0000_0003);
        caps <= 4'h1;
        repeat (4) @(posedge clk_i);
        cmp("cap_partial", 0, cap_on);
        cmp("peak_torque", 250, {24'h00_0000, trq});
        rd_chk("status", 8'h20, 32'h0000_0000);
        caps <= 4'h3;
        repeat (4) @(posedge clk_i);
        cmp("cap_all", 1, cap_on);
        cmp("capped_torque", 50, {24'h00_0000, trq});
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        finish_test();
    end
endmodule : tb

// ### tb/terminal_host.sv
// host controller model driving the entry select and cap terminals
`timescale 1ns/1ps
module terminal_host (
    // requests from the test sequence
    input wire logic [opdata_pkg::ENTRY_W-1:0] entry_req_i,
    input wire logic use_external_i,
    input wire logic [opdata_pkg::NUM_TERMS-1:0] cap_levels_i,
    // input terminals of the device
    output logic [opdata_pkg::ENTRY_W-1:0] data_select_o,
    output logic [opdata_pkg::NUM_TERMS-1:0] torque_cap_enable_input_o
);
    // external speed source needs data_select_bit0 on
    assign data_select_o = entry_req_i | {3'b000, use_external_i};
    assign torque_cap_enable_input_o = cap_levels_i;
endmodule : terminal_host
